/* File: design/tic_pkg.sv */
// package: register map, field layout and timing constants of the interval timekeeper
package tic_pkg;
  // special function register addresses
  localparam logic [7:0] TIC_ADDR_CONTROL  = 8'hA1;
  localparam logic [7:0] TIC_ADDR_SUBSEC   = 8'hA2;
  localparam logic [7:0] TIC_ADDR_SECONDS  = 8'hA3;
  localparam logic [7:0] TIC_ADDR_MINUTES  = 8'hA4;
  localparam logic [7:0] TIC_ADDR_HOURS    = 8'hA5;
  localparam logic [7:0] TIC_ADDR_INTERVAL = 8'hA6;
  // control register field positions
  localparam int TIC_BIT_HOUR_FMT  = 6;
  localparam int TIC_BIT_TBASE_HI  = 5;
  localparam int TIC_BIT_TBASE_LO  = 4;
  localparam int TIC_BIT_SINGLE    = 3;
  localparam int TIC_BIT_MATCH     = 2;
  localparam int TIC_BIT_INT_EN    = 1;
  localparam int TIC_BIT_CLK_EN    = 0;
  // reset values
  localparam logic [7:0] TIC_RST_CONTROL = 8'h00;
  localparam logic [7:0] TIC_RST_COUNT   = 8'h00;
  // counter limits
  localparam logic [7:0] TIC_SUBSEC_MAX  = 8'h7F;
  localparam logic [7:0] TIC_SEC_MAX     = 8'h3B;
  localparam logic [7:0] TIC_MIN_MAX     = 8'h3B;
  localparam logic [7:0] TIC_HOUR24_MAX  = 8'h17;
  localparam logic [7:0] TIC_HOUR256_MAX = 8'hFF;
  localparam logic [7:0] TIC_ZERO        = 8'h00;
  localparam logic [7:0] TIC_ONE         = 8'h01;
  // timebase: one sub-second tick per 1/128 s from the 32.768 kHz crystal
  localparam real TIC_XTAL_HZ      = 32768.0;
  localparam real TIC_SUBSEC_HZ    = 128.0;
  localparam int  TIC_XTAL_PER_SUB = int'(TIC_XTAL_HZ / TIC_SUBSEC_HZ);
  localparam logic [7:0] TIC_PRE_MAX = 8'(TIC_XTAL_PER_SUB - 1);
  // wake-up vector
  localparam logic [15:0] TIC_WAKE_VECTOR = 16'h0053;
  // interval step rate selection
  typedef enum logic [1:0] {
    TIC_TB_SUBSEC,
    TIC_TB_SECOND,
    TIC_TB_MINUTE,
    TIC_TB_HOUR
  } tic_tbase_e;
  // special function register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tic_sfr_s;
  // carry flags out of the time cascade
  typedef struct packed {
    logic sub;
    logic sec;
    logic min;
    logic hour;
  } tic_carry_s;
endpackage

/* File: design/tic_wrap_count.sv */
// wrapping 8-bit counter stage with preload and restore
`timescale 1ns/1ps
`default_nettype none
module tic_wrap_count
  import tic_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // control
  input  wire logic       step,
  input  wire logic [7:0] max_val,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  // state
  output logic      [7:0] count_q,
  output logic            wrap
);
  // wrap when stepping at the limit
  assign wrap = step && (count_q == max_val);

  // counter update, load wins over step
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= TIC_RST_COUNT;
    end else if (load) begin
      count_q <= load_val;
    end else if (wrap) begin
      count_q <= TIC_ZERO;
    end else if (step) begin
      count_q <= count_q + TIC_ONE;
    end
  end
endmodule
`default_nettype wire

/* File: design/tic_timekeeper.sv */
// top: time-of-day counter and interval timer on the crystal clock
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: hour format bit one counts hours 0..23, zero counts 0..255.
// R2: timebase field picks interval step: 1/128 s, second, minute, hour.
// R3: single mode gives one timeout which clears the interval enable.
// R4: repeat mode reloads the interval counter each timeout and continues.
// R5: flag sets when interval counter equals compare value, stays until cleared.
// R6: flag with interval interrupt enabled raises the interrupt request.
// R7: interval counter advances only while interval enable is one.
// R8: time clock enable gates the timebase to all counters.
// R9: clearing time clock enable restores registers to last written values.
// R10: time registers take writes while time clock is off; software preloads.
// R11: sub-second steps each 1/128 s, wraps 127 to 0, bumps seconds.
// R12: seconds count 0..59, then wrap and bump minutes.
// R13: minutes count 0..59, then wrap and bump hours.
// R14: in 24-hour format hours count 0..23 then wrap to zero.
// R15: software loads compare value 0..255; all values valid.
// R16: at power-on compare value and four time registers are zero.
// R17: whole block runs on the 32.768 kHz crystal, also in power-down.
// R18: flag in power-down with interrupt enabled wakes core at vector 0053H.
// R19: counter cleared to zero on reload and on enable rising.
module tic_timekeeper
  import tic_pkg::*;
(
  // crystal clock and power-on reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // special function register access from the core
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  // interrupt and wake-up
  input  wire logic        irq_enable,
  input  wire logic        power_down,
  output logic             irq_req,
  output logic             wake_req,
  output logic      [15:0] wake_vector
);
  tic_sfr_s   sfr;
  tic_carry_s carry;
  logic [7:0] control_w;
  logic [3:0] config_q;
  logic       match_q;
  logic       int_en_q;
  logic       clk_en_q;
  logic [7:0] interval_value_q;
  logic [7:0] interval_count_q;
  logic [7:0] pre_q;
  logic [7:0] sub_wr_q;
  logic [7:0] sec_wr_q;
  logic [7:0] min_wr_q;
  logic [7:0] hour_wr_q;
  logic [7:0] sub_cnt;
  logic [7:0] sec_cnt;
  logic [7:0] min_cnt;
  logic [7:0] hour_cnt;
  logic [7:0] hour_max;
  logic       clk_en;
  logic       int_en;
  logic       int_en_d1_q;
  logic       tick;
  logic       restore;
  logic       interval_step;
  logic       timeout;
  logic       ctrl_wr;
  logic [7:0] rdata_d;
  tic_tbase_e tbase;

  // decode a register write at a given address
  function automatic logic wr_at(input tic_sfr_s s, input logic [7:0] a);
    return s.wr && (s.addr == a);
  endfunction

  // a time register takes a preload only while the time clock is stopped
  function automatic logic preload_at(input tic_sfr_s s, input logic [7:0] a,
                                      input logic stopped);
    return stopped && wr_at(s, a);
  endfunction

  // bundle the access signals
  assign sfr     = '{wr: sfr_wr, rd: sfr_rd, addr: sfr_addr, wdata: sfr_wdata};
  assign ctrl_wr = wr_at(sfr, TIC_ADDR_CONTROL);
  assign clk_en  = clk_en_q;
  assign int_en  = int_en_q;
  assign tbase   = tic_tbase_e'(control_w[TIC_BIT_TBASE_HI:TIC_BIT_TBASE_LO]);  // R2

  // restore pulse on the falling edge of the time clock enable
  assign restore = ctrl_wr && clk_en && !sfr.wdata[TIC_BIT_CLK_EN];  // R9

  // 1/128 s prescaler from the crystal, cleared while disabled
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= TIC_RST_COUNT;
    end else if (!clk_en) begin  // R8
      pre_q <= TIC_ZERO;
    end else if (pre_q == TIC_PRE_MAX) begin  // R17
      pre_q <= TIC_ZERO;
    end else begin
      pre_q <= pre_q + TIC_ONE;
    end
  end
  assign tick = clk_en && (pre_q == TIC_PRE_MAX);  // R8 R11

  // last value written to the sub-second register while stopped
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sub_wr_q <= TIC_RST_COUNT;  // R16
    end else if (preload_at(sfr, TIC_ADDR_SUBSEC, !clk_en)) begin  // R10
      sub_wr_q <= sfr.wdata;
    end
  end

  // last value written to the seconds register while stopped
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sec_wr_q <= TIC_RST_COUNT;  // R16
    end else if (preload_at(sfr, TIC_ADDR_SECONDS, !clk_en)) begin  // R10
      sec_wr_q <= sfr.wdata;
    end
  end

  // last value written to the minutes register while stopped
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      min_wr_q <= TIC_RST_COUNT;  // R16
    end else if (preload_at(sfr, TIC_ADDR_MINUTES, !clk_en)) begin  // R10
      min_wr_q <= sfr.wdata;
    end
  end

  // last value written to the hours register while stopped
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hour_wr_q <= TIC_RST_COUNT;  // R16
    end else if (preload_at(sfr, TIC_ADDR_HOURS, !clk_en)) begin  // R10
      hour_wr_q <= sfr.wdata;
    end
  end

  // hour limit by format
  assign hour_max = control_w[TIC_BIT_HOUR_FMT] ? TIC_HOUR24_MAX : TIC_HOUR256_MAX;  // R1 R14

  // time cascade
  tic_wrap_count u_sub (
    .clock    (clock),
    .rst_b    (rst_b),
    .step     (tick),
    .max_val  (TIC_SUBSEC_MAX),
    .load     (restore || (!clk_en && wr_at(sfr, TIC_ADDR_SUBSEC))),
    .load_val (restore ? sub_wr_q : sfr.wdata),
    .count_q  (sub_cnt),
    .wrap     (carry.sub)
  );  // R11
  tic_wrap_count u_sec (
    .clock    (clock),
    .rst_b    (rst_b),
    .step     (carry.sub),
    .max_val  (TIC_SEC_MAX),
    .load     (restore || (!clk_en && wr_at(sfr, TIC_ADDR_SECONDS))),
    .load_val (restore ? sec_wr_q : sfr.wdata),
    .count_q  (sec_cnt),
    .wrap     (carry.sec)
  );  // R12
  tic_wrap_count u_min (
    .clock    (clock),
    .rst_b    (rst_b),
    .step     (carry.sec),
    .max_val  (TIC_MIN_MAX),
    .load     (restore || (!clk_en && wr_at(sfr, TIC_ADDR_MINUTES))),
    .load_val (restore ? min_wr_q : sfr.wdata),
    .count_q  (min_cnt),
    .wrap     (carry.min)
  );  // R13
  tic_wrap_count u_hour (
    .clock    (clock),
    .rst_b    (rst_b),
    .step     (carry.min),
    .max_val  (hour_max),
    .load     (restore || (!clk_en && wr_at(sfr, TIC_ADDR_HOURS))),
    .load_val (restore ? hour_wr_q : sfr.wdata),
    .count_q  (hour_cnt),
    .wrap     (carry.hour)
  );  // R14

  // interval step source selection
  always_comb begin
    case (tbase)  // R2
      TIC_TB_SUBSEC: interval_step = tick;
      TIC_TB_SECOND: interval_step = carry.sub;
      TIC_TB_MINUTE: interval_step = carry.sec;
      TIC_TB_HOUR:   interval_step = carry.min;
      default:       interval_step = 1'b0;
    endcase
  end

  // compare value register, any 0..255 accepted
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      interval_value_q <= TIC_RST_COUNT;  // R16
    end else if (wr_at(sfr, TIC_ADDR_INTERVAL)) begin
      interval_value_q <= sfr.wdata;  // R15
    end
  end

  // timeout when the stepped counter reaches the compare value
  assign timeout = int_en && interval_step && clk_en
                   && ((interval_count_q + TIC_ONE) == interval_value_q);  // R5

  // enable history for rising-edge clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      int_en_d1_q <= 1'b0;
    end else begin
      int_en_d1_q <= int_en;
    end
  end

  // interval counter
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      interval_count_q <= TIC_RST_COUNT;
    end else if ((int_en && !int_en_d1_q) || restore) begin
      interval_count_q <= TIC_ZERO;  // R19
    end else if (timeout) begin
      interval_count_q <= TIC_ZERO;  // R4 R19
    end else if (int_en && interval_step) begin  // R7 R8
      interval_count_q <= interval_count_q + TIC_ONE;
    end
  end

  // software configuration: hour format, timebase and single shot
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      config_q <= TIC_RST_CONTROL[TIC_BIT_HOUR_FMT:TIC_BIT_SINGLE];
    end else if (ctrl_wr) begin
      config_q <= sfr.wdata[TIC_BIT_HOUR_FMT:TIC_BIT_SINGLE];  // R1 R2
    end
  end

  // interval flag; a hardware set wins over a software clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      match_q <= TIC_RST_CONTROL[TIC_BIT_MATCH];
    end else if (timeout) begin
      match_q <= 1'b1;  // R5
    end else if (ctrl_wr && !sfr.wdata[TIC_BIT_MATCH]) begin
      match_q <= 1'b0;  // R5
    end
  end

  // interval enable; a single-shot timeout overrides a write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      int_en_q <= TIC_RST_CONTROL[TIC_BIT_INT_EN];
    end else if (timeout && control_w[TIC_BIT_SINGLE]) begin
      int_en_q <= 1'b0;  // R3
    end else if (ctrl_wr) begin
      int_en_q <= sfr.wdata[TIC_BIT_INT_EN];  // R7
    end
  end

  // time clock enable
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clk_en_q <= TIC_RST_CONTROL[TIC_BIT_CLK_EN];
    end else if (ctrl_wr) begin
      clk_en_q <= sfr.wdata[TIC_BIT_CLK_EN];  // R8
    end
  end

  // control byte as software reads it, reserved bit low
  assign control_w = {1'b0, config_q, match_q, int_en_q, clk_en_q};

  // interrupt and wake-up requests
  assign irq_req     = match_q && irq_enable;  // R6
  assign wake_req    = irq_req && power_down;  // R18
  assign wake_vector = TIC_WAKE_VECTOR;  // R18

  // read data mux
  always_comb begin
    case (sfr.addr)
      TIC_ADDR_CONTROL:  rdata_d = control_w;
      TIC_ADDR_SUBSEC:   rdata_d = sub_cnt;
      TIC_ADDR_SECONDS:  rdata_d = sec_cnt;
      TIC_ADDR_MINUTES:  rdata_d = min_cnt;
      TIC_ADDR_HOURS:    rdata_d = hour_cnt;
      TIC_ADDR_INTERVAL: rdata_d = interval_value_q;
      default:           rdata_d = TIC_ZERO;
    endcase
  end

  // read data register, held between reads
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= TIC_ZERO;
    end else if (sfr.rd) begin
      sfr_rdata <= rdata_d;
    end
  end

  // hit flag, one cycle after a read inside the map
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sfr_hit <= 1'b0;
    end else begin
      sfr_hit <= sfr.rd && (sfr.addr >= TIC_ADDR_CONTROL) && (sfr.addr <= TIC_ADDR_INTERVAL);
    end
  end
endmodule
`default_nettype wire

/* File: bench/tic_timekeeper_sva.sv */
// checker: port-level properties of the interval timekeeper
`timescale 1ns/1ps
`default_nettype none
module tic_timekeeper_chk
  import tic_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // register access
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_hit,
  // interrupt and wake-up
  input wire logic        irq_enable,
  input wire logic        power_down,
  input wire logic        irq_req,
  input wire logic        wake_req,
  input wire logic [15:0] wake_vector
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic       run_q;
  logic [2:0] idx_q;
  logic [7:0] shadow_q [8];
  wire        map_w = sfr_addr >= TIC_ADDR_CONTROL && sfr_addr <= TIC_ADDR_INTERVAL;
  wire        time_w = sfr_addr >= TIC_ADDR_SUBSEC && sfr_addr <= TIC_ADDR_HOURS;
  wire        clr_w = sfr_wr && sfr_addr == TIC_ADDR_CONTROL && !sfr_wdata[TIC_BIT_MATCH];
  // clock enable and time values written while stopped
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 1'b0;
      idx_q <= 3'h0;
      for (int i = 0; i < 8; i++) shadow_q[i] <= 8'h00;
    end else begin
      idx_q <= sfr_addr[2:0];
      if (sfr_wr && sfr_addr == TIC_ADDR_CONTROL) run_q <= sfr_wdata[TIC_BIT_CLK_EN];
      else if (sfr_wr && time_w && !run_q) shadow_q[sfr_addr[2:0]] <= sfr_wdata;
    end
  end
  // read steps
  sequence rd_map_s;
    sfr_rd && map_w;
  endsequence
  sequence rd_time_s;
    sfr_rd && time_w && !run_q;
  endsequence
  wake_vector_a: assert property (wake_vector == TIC_WAKE_VECTOR)
    else $error("wake vector wrong");
  wake_gate_a: assert property (wake_req == (irq_req && power_down))
    else $error("wake request wrong");
  irq_gate_a: assert property (!irq_enable |-> !irq_req)
    else $error("request while interrupt disabled");
  restore_read_a: assert property (rd_time_s |=> sfr_rdata == shadow_q[idx_q])
    else $error("stopped time register not last written");
  clock_gate_a: assert property ($rose(irq_req) && $past(irq_enable) |-> $past(run_q))
    else $error("timeout with time clock off");
  flag_hold_a: assert property (irq_req && irq_enable && !clr_w |=> irq_req || !irq_enable)
    else $error("flag dropped without clear");
  read_hit_a: assert property (rd_map_s |=> sfr_hit)
    else $error("mapped read without hit");
  unmapped_read_a: assert property (sfr_rd && !map_w |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read answered");
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without read");
endmodule
bind tic_timekeeper tic_timekeeper_chk u_chk (.clock(clock), .rst_b(rst_b), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .sfr_hit(sfr_hit), .irq_enable(irq_enable), .power_down(power_down), .irq_req(irq_req),
  .wake_req(wake_req), .wake_vector(wake_vector));
`default_nettype wire

/* File: bench/tb.sv */
// testbench: register-level scenarios for the interval timekeeper
`timescale 1ns/1ps
`default_nettype none
module tb
  import tic_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        irq_enable = 1'b0;
  logic        power_down = 1'b0;
  logic [7:0]  sfr_rdata;
  logic        sfr_hit;
  logic        irq_req;
  logic        wake_req;
  logic [15:0] wake_vector;
  logic [7:0]  ctl;
  int          fail_count = 0;
  int          n_compared = 0;
  // free-running clock
  always #5 clock = ~clock;
  tic_timekeeper dut (.clock(clock), .rst_b(rst_b), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .irq_enable(irq_enable), .power_down(power_down), .irq_req(irq_req),
    .wake_req(wake_req), .wake_vector(wake_vector));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_wr    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    sfr_rd   <= 1'b1;
    sfr_addr <= a;
    @(posedge clock);
    sfr_rd <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk({8'h00, sfr_rdata}, {8'h00, exp});
  endtask
  // read until the masked value appears, bounded; running out is a mismatch
  task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] w);
    for (int i = 0; i < 400; i++) begin
      rd(a);
      if ((sfr_rdata & m) == w) break;
    end
    chk({8'h00, sfr_rdata & m}, {8'h00, w});
  endtask
  // stop, preload time and compare value, then start with a control byte
  task automatic run(input logic [7:0] c, input logic [7:0] s0, input logic [7:0] s1,
                     input logic [7:0] s2, input logic [7:0] s3, input logic [7:0] v);
    wr(TIC_ADDR_CONTROL, 8'h00);
    wr(TIC_ADDR_SUBSEC, s0);
    wr(TIC_ADDR_SECONDS, s1);
    wr(TIC_ADDR_MINUTES, s2);
    wr(TIC_ADDR_HOURS, s3);
    wr(TIC_ADDR_INTERVAL, v);
    wr(TIC_ADDR_CONTROL, c);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #200_000;
    fail_count++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    for (int a = 8'hA1; a <= 8'hA6; a++) rchk(8'(a), 8'h00);
    rchk(8'hA0, 8'h00);
    chk(wake_vector, 16'h0053);
    wr(TIC_ADDR_SECONDS, 8'h12);
    rchk(TIC_ADDR_SECONDS, 8'h12);
    wr(TIC_ADDR_CONTROL, 8'h01);
    poll(TIC_ADDR_SUBSEC, 8'hFF, 8'h01);
    wr(TIC_ADDR_SECONDS, 8'h20);
    rchk(TIC_ADDR_SECONDS, 8'h12);
    wr(TIC_ADDR_CONTROL, 8'h00);
    rchk(TIC_ADDR_SUBSEC, 8'h00);
    // full cascade rollover in both hour formats
    run(8'h41, 8'h7F, 8'h3B, 8'h3B, 8'h17, 8'h00);
    poll(TIC_ADDR_HOURS, 8'hFF, 8'h00);
    rchk(TIC_ADDR_HOURS, 8'h00);
    rchk(TIC_ADDR_MINUTES, 8'h00);
    rchk(TIC_ADDR_SECONDS, 8'h00);
    rchk(TIC_ADDR_SUBSEC, 8'h00);
    run(8'h01, 8'h7F, 8'h3B, 8'h3B, 8'h17, 8'h00);
    poll(TIC_ADDR_HOURS, 8'hFF, 8'h18);
    rchk(TIC_ADDR_HOURS, 8'h18);
    run(8'h01, 8'h7F, 8'h3B, 8'h3B, 8'hFF, 8'h00);
    poll(TIC_ADDR_HOURS, 8'hFF, 8'h00);
    rchk(TIC_ADDR_HOURS, 8'h00);
    // each timebase code, single shot, with the selected carry; codes 1 to 3 also without it
    for (int c = 0; c < 4; c++) begin
      for (int d = (c > 0) ? c - 1 : 0; d <= c; d++) begin
        ctl = 8'h0B | 8'(c << 4);
        run(ctl, (d >= 1) ? 8'h7F : 8'h00, (d >= 2) ? 8'h3B : 8'h00,
            (d >= 3) ? 8'h3B : 8'h00, 8'h00, 8'h01);
        if (d >= c) begin
          poll(TIC_ADDR_CONTROL, 8'h04, 8'h04);
          rchk(TIC_ADDR_CONTROL, (ctl & 8'hFD) | 8'h04);
        end else begin
          poll(TIC_ADDR_SUBSEC, 8'hFF, (d >= 1) ? 8'h00 : 8'h01);
          rchk(TIC_ADDR_CONTROL, ctl);
        end
      end
    end
    // repeating timeouts, interrupt request and wake-up
    @(posedge clock);
    irq_enable <= 1'b1;
    power_down <= 1'b1;
    run(8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02);
    poll(TIC_ADDR_CONTROL, 8'h04, 8'h04);
    rchk(TIC_ADDR_CONTROL, 8'h07);
    chk({15'h0000, irq_req}, 16'h0001);
    chk({15'h0000, wake_req}, 16'h0001);
    wr(TIC_ADDR_CONTROL, 8'h03);
    rchk(TIC_ADDR_CONTROL, 8'h03);
    chk({15'h0000, irq_req}, 16'h0000);
    poll(TIC_ADDR_CONTROL, 8'h04, 8'h04);
    rchk(TIC_ADDR_CONTROL, 8'h07);
    @(posedge clock);
    irq_enable <= 1'b0;
    rchk(TIC_ADDR_CONTROL, 8'h07);
    chk({15'h0000, irq_req}, 16'h0000);
    // interval enable off, then time clock off
    run(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01);
    poll(TIC_ADDR_SUBSEC, 8'hFF, 8'h02);
    rchk(TIC_ADDR_CONTROL, 8'h01);
    run(8'h02, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01);
    repeat (600) @(posedge clock);
    rchk(TIC_ADDR_SUBSEC, 8'h05);
    rchk(TIC_ADDR_CONTROL, 8'h02);
    end_sim();
  end
endmodule
`default_nettype wire
